// ===== inc/lcs_pkg.sv
// Constants shared by the light-curtain safety control block
// Summary of operation
// - Field interrupted about 5 s: display enters alignment mode.
// - Alignment mode maps top, middle, bottom thirds onto three segments.
// - Segment steady when third all clear, flashing when partly, dark when blocked.
// - Field free about 5 s: display returns to operating indication.
// - With interlock, outputs stay off after intrusion even once field clears.
// - With interlock, outputs stay off after power returns; explicit reset needed.
// - Interlock active purely from wiring, no further configuration step.
// - Reset accepted only as press then release lasting 0.15 s to 4 s.
// - Valid reset while interlock blocks switches safety outputs on.
// - Feedback monitoring enabled or disabled by wiring only.
// - Monitoring on: feedback circuit must be closed before each switch-on.
// - Monitoring on: feedback must open within 500 ms after switch-on.
// - Monitoring on: feedback must close within 500 ms after switch-off.
// - Failed check: outputs off, show E30 or E31, enter fault interlock.
// - Fault interlock left only by power cycle; reset input cannot clear it.
// - Factory default uses first transmission channel in every mode.
// - Transmission channel chosen from supply voltage polarity.
// - Reduced range lowers light power to about half nominal range.
// - Transmit power set from level on range-select input.
// - Power reduction is single unmonitored channel, never used for safety.
// - Normal operation display shows selected transmission channel number.
// - Non-locking errors auto-reset after 10 s without unauthorized restart.
package lcs_pkg;
    localparam longint unsigned LCS_CLK_KHZ = 250000;
    localparam longint unsigned LCS_ALIGN_MS = 5000;
    localparam longint unsigned LCS_PRESS_MIN_MS = 150;
    localparam longint unsigned LCS_PRESS_MAX_MS = 4000;
    localparam longint unsigned LCS_FB_CHK_MS = 500;
    localparam longint unsigned LCS_AUTORST_MS = 10000;
    localparam longint unsigned LCS_FLASH_MS = 250;
    localparam longint unsigned LCS_ALIGN_CYC = LCS_ALIGN_MS * LCS_CLK_KHZ;
    localparam longint unsigned LCS_PRESS_MIN_CYC = LCS_PRESS_MIN_MS * LCS_CLK_KHZ;
    localparam longint unsigned LCS_PRESS_MAX_CYC = LCS_PRESS_MAX_MS * LCS_CLK_KHZ;
    localparam longint unsigned LCS_FB_CHK_CYC = LCS_FB_CHK_MS * LCS_CLK_KHZ;
    localparam longint unsigned LCS_AUTORST_CYC = LCS_AUTORST_MS * LCS_CLK_KHZ;
    localparam longint unsigned LCS_FLASH_CYC = LCS_FLASH_MS * LCS_CLK_KHZ;
    localparam int LCS_NBEAM_DEF = 24;
    localparam int LCS_ADDR_W = 4;
    localparam logic [3:0] LCS_OFS_STATUS = 4'h0;
    localparam logic [3:0] LCS_OFS_DISPLAY = 4'h4;
    localparam logic [3:0] LCS_OFS_BOUND_MID = 4'h8;
    localparam logic [3:0] LCS_OFS_BOUND_BOT = 4'hC;
    localparam logic [15:0] LCS_BOUND_MID_RST = 16'h0008;
    localparam logic [15:0] LCS_BOUND_BOT_RST = 16'h0010;
    localparam logic [7:0] LCS_ERR_FB_STUCK = 8'h1E;
    localparam logic [7:0] LCS_ERR_FB_NOCLOSE = 8'h1F;
    localparam logic [7:0] LCS_ERR_FB_OPEN = 8'h20;
    localparam logic [7:0] LCS_CHAN_FIRST = 8'h01;
    localparam logic [7:0] LCS_CHAN_SECOND = 8'h02;
    localparam logic [1:0] LCS_DISP_CHAN = 2'h0;
    localparam logic [1:0] LCS_DISP_ERR = 2'h1;
    localparam logic [1:0] LCS_DISP_ALIGN = 2'h2;
    localparam int LCS_ST_OUT = 0;
    localparam int LCS_ST_BLOCK = 1;
    localparam int LCS_ST_FAULT = 2;
    localparam int LCS_ST_ERRWAIT = 3;
    localparam int LCS_ST_ALIGN = 4;
    localparam int LCS_ST_CHAN2 = 5;
    localparam int LCS_ST_RANGE = 6;
    localparam int LCS_ST_MONEN = 7;
    localparam int LCS_ST_ILKEN = 8;
    localparam int LCS_ST_FBCL = 9;
    localparam int LCS_DSP_KIND = 8;
    localparam int LCS_DSP_SEG = 12;
endpackage

// ===== core/lcs_safety_ctrl.sv
// Safety output sequencing, feedback checks, display and channel/range selection
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lcs_safety_ctrl #(
    parameter int NBEAM = lcs_pkg::LCS_NBEAM_DEF,
    parameter logic [31:0] ALIGN_CYC = 32'(lcs_pkg::LCS_ALIGN_CYC),
    parameter logic [31:0] PRESS_MIN_CYC = 32'(lcs_pkg::LCS_PRESS_MIN_CYC),
    parameter logic [31:0] PRESS_MAX_CYC = 32'(lcs_pkg::LCS_PRESS_MAX_CYC),
    parameter logic [31:0] FB_CHK_CYC = 32'(lcs_pkg::LCS_FB_CHK_CYC),
    parameter logic [31:0] AUTORST_CYC = 32'(lcs_pkg::LCS_AUTORST_CYC),
    parameter logic [31:0] FLASH_CYC = 32'(lcs_pkg::LCS_FLASH_CYC)
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [lcs_pkg::LCS_ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [NBEAM-1:0] beams_clear, // Per-beam clear, index 0 at top
    input wire logic reset_button_pin, // Reset button, high while pressed
    input wire logic feedback_closed_pin, // Contactor feedback loop closed
    input wire logic wire_restart_interlock_pin, // Wiring selects restart_interlock
    input wire logic wire_feedback_monitor_pin, // Wiring selects contactor_feedback_monitor
    input wire logic supply_polarity_pin, // High when supply polarity reversed
    input wire logic range_select_pin, // High selects reduced range
    output logic safety_switching_output, // Safety output on
    output logic second_transmission_channel, // Channel select, low for first channel
    output logic tx_power_reduced, // Transmit power lowered
    output logic [1:0] disp_kind, // Display content kind
    output logic [7:0] disp_value, // Channel number or error code
    output logic [2:0] align_seg, // Alignment segments, bit 2 top
    output logic interlock_ready // Interlock blocking with field free
);
    typedef enum {lcs_locked, lcs_on, lcs_err_wait, lcs_fault} lcs_state_t;
    typedef enum {lcs_chk_idle, lcs_chk_on, lcs_chk_off} lcs_chk_t;

    // Pin synchronisers; interlock and monitoring held on until the wiring is through
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 6'h0C;
            pin_sync_reg <= 6'h0C;
        end else begin
            pin_meta_reg <= {range_select_pin, supply_polarity_pin, wire_feedback_monitor_pin,
                wire_restart_interlock_pin, feedback_closed_pin, reset_button_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic btn_s, fb_closed_s, ilk_en_s, mon_en_s, pol_s, range_s;
    assign {range_s, pol_s, mon_en_s, ilk_en_s, fb_closed_s, btn_s} = pin_sync_reg;

    logic field_clear;
    assign field_clear = &beams_clear;

    // Registers written by software: where the thirds begin
    logic [15:0] bound_mid_reg;
    logic [15:0] bound_bot_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bound_mid_reg <= lcs_pkg::LCS_BOUND_MID_RST;
            bound_bot_reg <= lcs_pkg::LCS_BOUND_BOT_RST;
        end else if (reg_wr && reg_addr == lcs_pkg::LCS_OFS_BOUND_MID) begin
            bound_mid_reg <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == lcs_pkg::LCS_OFS_BOUND_BOT) begin
            bound_bot_reg <= reg_wdata[15:0];
        end
    end

    // Reset button press timing
    logic btn_q_reg;
    logic [31:0] press_cnt_reg;
    logic reset_ok_reg;
    logic btn_fall;
    assign btn_fall = btn_q_reg && !btn_s;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            btn_q_reg <= 1'b0;
            press_cnt_reg <= 32'h0000_0000;
            reset_ok_reg <= 1'b0;
        end else begin
            btn_q_reg <= btn_s;
            if (!btn_s) begin
                press_cnt_reg <= 32'h0000_0000;
            end else if (press_cnt_reg <= PRESS_MAX_CYC) begin
                press_cnt_reg <= press_cnt_reg + 32'h0000_0001;
            end
            reset_ok_reg <= btn_fall && press_cnt_reg >= PRESS_MIN_CYC
                && press_cnt_reg <= PRESS_MAX_CYC;
        end
    end

    // Output state machine and feedback checks
    lcs_state_t state_reg, state_next;
    lcs_chk_t chk_reg;
    logic [31:0] fb_tmr_reg;
    logic [31:0] autorst_cnt_reg;
    logic [7:0] fault_code_reg;
    logic chk_met, fb_fail;
    assign chk_met = (chk_reg == lcs_chk_on) ? !fb_closed_s : fb_closed_s;
    assign fb_fail = chk_reg != lcs_chk_idle && !chk_met && fb_tmr_reg == FB_CHK_CYC - 32'h1;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lcs_locked: begin
                if (field_clear && (reset_ok_reg || !ilk_en_s)) begin
                    if (mon_en_s && !fb_closed_s) begin
                        state_next = lcs_err_wait;
                    end else begin
                        state_next = lcs_on;
                    end
                end
            end
            lcs_on: begin
                if (!field_clear) begin
                    state_next = lcs_locked;
                end
            end
            lcs_err_wait: begin
                if (autorst_cnt_reg == AUTORST_CYC - 32'h1) begin
                    state_next = lcs_locked;
                end
            end
            lcs_fault: state_next = lcs_fault;
        endcase
        if (fb_fail) begin
            state_next = lcs_fault;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= lcs_locked;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chk_reg <= lcs_chk_idle;
            fb_tmr_reg <= 32'h0000_0000;
        end else if (!mon_en_s) begin
            chk_reg <= lcs_chk_idle;
            fb_tmr_reg <= 32'h0000_0000;
        end else if (state_reg != lcs_on && state_next == lcs_on) begin
            chk_reg <= lcs_chk_on;
            fb_tmr_reg <= 32'h0000_0000;
        end else if (state_reg == lcs_on && state_next == lcs_locked) begin
            chk_reg <= lcs_chk_off;
            fb_tmr_reg <= 32'h0000_0000;
        end else if (chk_reg != lcs_chk_idle) begin
            if (chk_met || fb_fail) begin
                chk_reg <= lcs_chk_idle;
            end else begin
                fb_tmr_reg <= fb_tmr_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_code_reg <= 8'h00;
        end else if (fb_fail && state_reg != lcs_fault) begin
            fault_code_reg <= (chk_reg == lcs_chk_on) ? lcs_pkg::LCS_ERR_FB_STUCK
                : lcs_pkg::LCS_ERR_FB_NOCLOSE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            autorst_cnt_reg <= 32'h0000_0000;
        end else if (state_reg == lcs_err_wait) begin
            autorst_cnt_reg <= autorst_cnt_reg + 32'h0000_0001;
        end else begin
            autorst_cnt_reg <= 32'h0000_0000;
        end
    end

    logic out_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= state_next == lcs_on;
        end
    end
    assign safety_switching_output = out_reg;

    // Channel and range; range is a plain unmonitored level, no safety logic uses it
    logic chan2_reg;
    logic range_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chan2_reg <= 1'b0;
            range_reg <= 1'b0;
        end else begin
            chan2_reg <= pol_s;
            range_reg <= range_s;
        end
    end
    assign second_transmission_channel = chan2_reg;
    assign tx_power_reduced = range_reg;

    // Alignment mode entry and exit delays
    logic align_reg;
    logic [31:0] align_cnt_reg;
    logic align_cond;
    assign align_cond = align_reg ? field_clear : !field_clear;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            align_reg <= 1'b0;
            align_cnt_reg <= 32'h0000_0000;
        end else if (!align_cond) begin
            align_cnt_reg <= 32'h0000_0000;
        end else if (align_cnt_reg == ALIGN_CYC - 32'h1) begin
            align_reg <= !align_reg;
            align_cnt_reg <= 32'h0000_0000;
        end else begin
            align_cnt_reg <= align_cnt_reg + 32'h0000_0001;
        end
    end

    // Flash clock for partly clear thirds
    logic [31:0] flash_cnt_reg;
    logic blink_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flash_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
        end else if (flash_cnt_reg == FLASH_CYC - 32'h1) begin
            flash_cnt_reg <= 32'h0000_0000;
            blink_reg <= !blink_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
        end
    end

    // Segment level for beams lo..hi-1: steady, flashing or dark
    function automatic logic seg_level(input logic [NBEAM-1:0] b, input int lo, input int hi,
        input logic blink);
        logic all_clr;
        logic any_clr;
        all_clr = 1'b1;
        any_clr = 1'b0;
        for (int i = 0; i < NBEAM; i++) begin
            if (i >= lo && i < hi) begin
                all_clr = all_clr & b[i];
                any_clr = any_clr | b[i];
            end
        end
        return all_clr ? 1'b1 : (any_clr ? blink : 1'b0);
    endfunction

    logic [2:0] seg_now;
    always_comb begin
        seg_now[2] = seg_level(beams_clear, 0, int'(bound_mid_reg), blink_reg);
        seg_now[1] = seg_level(beams_clear, int'(bound_mid_reg), int'(bound_bot_reg), blink_reg);
        seg_now[0] = seg_level(beams_clear, int'(bound_bot_reg), NBEAM, blink_reg);
    end

    // Display selection: errors first, then alignment, then channel
    logic [1:0] disp_kind_reg;
    logic [7:0] disp_value_reg;
    logic [2:0] align_seg_reg;
    logic ready_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            disp_kind_reg <= lcs_pkg::LCS_DISP_CHAN;
            disp_value_reg <= lcs_pkg::LCS_CHAN_FIRST;
            align_seg_reg <= 3'h0;
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ilk_en_s && state_reg == lcs_locked && field_clear;
            align_seg_reg <= align_reg ? seg_now : 3'h0;
            if (state_reg == lcs_fault) begin
                disp_kind_reg <= lcs_pkg::LCS_DISP_ERR;
                disp_value_reg <= fault_code_reg;
            end else if (state_reg == lcs_err_wait) begin
                disp_kind_reg <= lcs_pkg::LCS_DISP_ERR;
                disp_value_reg <= lcs_pkg::LCS_ERR_FB_OPEN;
            end else if (align_reg) begin
                disp_kind_reg <= lcs_pkg::LCS_DISP_ALIGN;
                disp_value_reg <= 8'h00;
            end else begin
                disp_kind_reg <= lcs_pkg::LCS_DISP_CHAN;
                disp_value_reg <= chan2_reg ? lcs_pkg::LCS_CHAN_SECOND : lcs_pkg::LCS_CHAN_FIRST;
            end
        end
    end
    assign disp_kind = disp_kind_reg;
    assign disp_value = disp_value_reg;
    assign align_seg = align_seg_reg;
    assign interlock_ready = ready_reg;

    // Register read port
    logic [31:0] status_word, display_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[lcs_pkg::LCS_ST_OUT] = out_reg;
        status_word[lcs_pkg::LCS_ST_BLOCK] = ilk_en_s && state_reg == lcs_locked;
        status_word[lcs_pkg::LCS_ST_FAULT] = state_reg == lcs_fault;
        status_word[lcs_pkg::LCS_ST_ERRWAIT] = state_reg == lcs_err_wait;
        status_word[lcs_pkg::LCS_ST_ALIGN] = align_reg;
        status_word[lcs_pkg::LCS_ST_CHAN2] = chan2_reg;
        status_word[lcs_pkg::LCS_ST_RANGE] = range_reg;
        status_word[lcs_pkg::LCS_ST_MONEN] = mon_en_s;
        status_word[lcs_pkg::LCS_ST_ILKEN] = ilk_en_s;
        status_word[lcs_pkg::LCS_ST_FBCL] = fb_closed_s;
        display_word = 32'h0000_0000;
        display_word[7:0] = disp_value_reg;
        display_word[lcs_pkg::LCS_DSP_KIND +: 2] = disp_kind_reg;
        display_word[lcs_pkg::LCS_DSP_SEG +: 3] = align_seg_reg;
    end

    logic [31:0] rdata_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (!reg_rd) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (reg_addr)
                lcs_pkg::LCS_OFS_STATUS: rdata_reg <= status_word;
                lcs_pkg::LCS_OFS_DISPLAY: rdata_reg <= display_word;
                lcs_pkg::LCS_OFS_BOUND_MID: rdata_reg <= {16'h0000, bound_mid_reg};
                lcs_pkg::LCS_OFS_BOUND_BOT: rdata_reg <= {16'h0000, bound_bot_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign reg_rdata = rdata_reg;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_switch_on;
        !out_reg ##1 out_reg;
    endsequence
    sequence s_release_short;
        btn_fall && press_cnt_reg < PRESS_MIN_CYC;
    endsequence

    property p_off_on_intrusion;
        !field_clear |=> !safety_switching_output;
    endproperty
    a_off_on_intrusion: assert property (p_off_on_intrusion)
        else $error("output on while field interrupted");

    property p_hold_without_reset;
        (state_reg == lcs_locked && ilk_en_s && !reset_ok_reg) |=> !safety_switching_output;
    endproperty
    a_hold_without_reset: assert property (p_hold_without_reset)
        else $error("output on without reset");

    property p_on_after_reset;
        (state_reg == lcs_locked && reset_ok_reg && field_clear && !fb_fail
            && (!mon_en_s || fb_closed_s)) |=> safety_switching_output && state_reg == lcs_on;
    endproperty
    a_on_after_reset: assert property (p_on_after_reset)
        else $error("valid reset did not switch output on");

    property p_closed_before_on;
        s_switch_on |-> (!$past(mon_en_s) || $past(fb_closed_s));
    endproperty
    a_closed_before_on: assert property (p_closed_before_on)
        else $error("switch-on with feedback open");

    property p_short_press_ignored;
        s_release_short |=> !reset_ok_reg;
    endproperty
    a_short_press_ignored: assert property (p_short_press_ignored)
        else $error("short press accepted");

    property p_fault_sticky;
        state_reg == lcs_fault |=> state_reg == lcs_fault && !safety_switching_output;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("left fault interlock");

    property p_fault_on_fail;
        (fb_fail && state_reg != lcs_fault) |=> (state_reg == lcs_fault && !out_reg)
            ##1 (disp_kind == lcs_pkg::LCS_DISP_ERR && (disp_value == lcs_pkg::LCS_ERR_FB_STUCK
            || disp_value == lcs_pkg::LCS_ERR_FB_NOCLOSE));
    endproperty
    a_fault_on_fail: assert property (p_fault_on_fail)
        else $error("failed feedback check not reported");

    property p_open_after_on;
        (chk_reg == lcs_chk_on && fb_closed_s && fb_tmr_reg == FB_CHK_CYC - 32'h1)
            |=> state_reg == lcs_fault;
    endproperty
    a_open_after_on: assert property (p_open_after_on)
        else $error("feedback stuck closed not caught");

    property p_close_after_off;
        (chk_reg == lcs_chk_off && !fb_closed_s && fb_tmr_reg == FB_CHK_CYC - 32'h1)
            |=> state_reg == lcs_fault;
    endproperty
    a_close_after_off: assert property (p_close_after_off)
        else $error("feedback not reclosed not caught");

    property p_align_enter;
        (!align_reg && !field_clear && align_cnt_reg == ALIGN_CYC - 32'h1) |=> align_reg
            ##1 disp_kind == lcs_pkg::LCS_DISP_ALIGN;
    endproperty
    a_align_enter: assert property (p_align_enter)
        else $error("alignment mode not entered");

    property p_align_exit;
        (align_reg && field_clear && align_cnt_reg == ALIGN_CYC - 32'h1) |=> !align_reg;
    endproperty
    a_align_exit: assert property (p_align_exit)
        else $error("alignment mode not left");

    property p_channel_display;
        (state_reg == lcs_locked && !align_reg) |=> disp_kind == lcs_pkg::LCS_DISP_CHAN
            && disp_value == ($past(chan2_reg) ? lcs_pkg::LCS_CHAN_SECOND
            : lcs_pkg::LCS_CHAN_FIRST);
    endproperty
    a_channel_display: assert property (p_channel_display)
        else $error("channel display wrong");

endmodule // lcs_safety_ctrl
`default_nettype wire

// ===== test/lcs_contactor_model.sv
// Contactor model: normally closed feedback contact trailing the safety output
`timescale 1ns/1ps
`default_nettype none
module lcs_contactor_model (
    input wire logic clk_sys, // System clock
    input wire logic coil_on, // Safety output driving the coil
    input wire logic [1:0] mode, // 0 healthy, 1 welded closed, 2 stuck open
    output logic feedback_closed_pin // Feedback contact closed
);
    logic [2:0] lag_reg = 3'h0;
    // Contact follows the coil three cycles late, as a real armature does
    always_ff @(posedge clk_sys) begin
        lag_reg <= {lag_reg[1:0], coil_on};
    end
    assign feedback_closed_pin = (mode == 2'h1) | ((mode == 2'h0) & ~lag_reg[2]);
endmodule // lcs_contactor_model
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the safety control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] beams_clear = 24'hFF_FFFF;
    logic reset_button_pin = 1'b0;
    logic wire_restart_interlock_pin = 1'b1;
    logic wire_feedback_monitor_pin = 1'b1;
    logic supply_polarity_pin = 1'b0;
    logic range_select_pin = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [31:0] reg_rdata, d;
    logic feedback_closed_pin, safety_switching_output, second_transmission_channel;
    logic tx_power_reduced, interlock_ready;
    logic [1:0] disp_kind;
    logic [7:0] disp_value;
    logic [2:0] align_seg;
    int err_total = 0;
    int n_compared = 0;
    int hi, lo;
    always #2 clk_sys = ~clk_sys;
    lcs_safety_ctrl #(.ALIGN_CYC(32'h0000_0032), .PRESS_MIN_CYC(32'h0000_0005),
        .PRESS_MAX_CYC(32'h0000_0028), .FB_CHK_CYC(32'h0000_0014),
        .AUTORST_CYC(32'h0000_003C), .FLASH_CYC(32'h0000_0004)) lcs_safety_ctrl_i (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .beams_clear,
        .reset_button_pin, .feedback_closed_pin, .wire_restart_interlock_pin,
        .wire_feedback_monitor_pin, .supply_polarity_pin, .range_select_pin,
        .safety_switching_output, .second_transmission_channel, .tx_power_reduced,
        .disp_kind, .disp_value, .align_seg, .interlock_ready);
    lcs_contactor_model lcs_contactor_model_i (.clk_sys, .coil_on(safety_switching_output),
        .mode, .feedback_closed_pin);
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= ~w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic press(input int n);
        @(posedge clk_sys) reset_button_pin <= 1'b1;
        repeat (n) @(posedge clk_sys);
        reset_button_pin <= 1'b0;
        tick(8);
    endtask
    task automatic do_reset;
        @(posedge clk_sys) rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        tick(4);
    endtask
    initial begin
        do_reset;
        chk({safety_switching_output, second_transmission_channel, tx_power_reduced,
            interlock_ready, disp_kind, disp_value}, 14'h0401);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk(d, 32'h0000_0010);
        bus(1'b1, 4'h8, 32'h0000_000A);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chk(d, 32'h0000_000A);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk(d, 32'h0000_0000);
        press(3);
        chk(safety_switching_output, 1'b0);
        press(45);
        chk(safety_switching_output, 1'b0);
        press(10);
        chk(safety_switching_output, 1'b1);
        tick(40);
        bus(1'b0, 4'h0, 32'h0000_0000);
        chk(d[9:0], 10'h181);
        @(posedge clk_sys) beams_clear <= 24'h00_0000;
        tick(5);
        chk(safety_switching_output, 1'b0);
        tick(55);
        chk(disp_kind, 2'h2);
        @(posedge clk_sys) beams_clear <= 24'h0F_03FF;
        tick(2);
        hi = 0;
        lo = 0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            hi += (align_seg[0] === 1'b1);
            lo += (align_seg[0] === 1'b0);
            chk(align_seg[2:1], 2'b10);
        end
        chk(hi > 0 && lo > 0, 1'b1);
        @(posedge clk_sys) beams_clear <= 24'hFF_FFFF;
        tick(20);
        chk({safety_switching_output, disp_kind}, 3'b010);
        tick(40);
        chk({safety_switching_output, disp_kind, disp_value}, 11'h001);
        @(posedge clk_sys) supply_polarity_pin <= 1'b1;
        range_select_pin <= 1'b1;
        tick(6);
        chk({second_transmission_channel, tx_power_reduced, disp_value}, 10'h302);
        @(posedge clk_sys) supply_polarity_pin <= 1'b0;
        range_select_pin <= 1'b0;
        press(10);
        @(posedge clk_sys) mode <= 2'h2;
        beams_clear <= 24'h00_0000;
        tick(35);
        chk({safety_switching_output, disp_kind, disp_value}, 11'h11F);
        @(posedge clk_sys) mode <= 2'h0;
        beams_clear <= 24'hFF_FFFF;
        press(10);
        chk(safety_switching_output, 1'b0);
        do_reset;
        @(posedge clk_sys) mode <= 2'h1;
        press(10);
        chk(safety_switching_output, 1'b1);
        tick(25);
        chk({safety_switching_output, disp_kind, disp_value}, 11'h11E);
        do_reset;
        @(posedge clk_sys) mode <= 2'h2;
        tick(5);
        press(10);
        chk({safety_switching_output, disp_kind, disp_value}, 11'h120);
        @(posedge clk_sys) mode <= 2'h0;
        tick(65);
        chk({safety_switching_output, disp_kind, disp_value}, 11'h001);
        @(posedge clk_sys) wire_restart_interlock_pin <= 1'b0;
        beams_clear <= 24'h00_0000;
        tick(5);
        @(posedge clk_sys) beams_clear <= 24'hFF_FFFF;
        tick(6);
        chk(safety_switching_output, 1'b1);
        @(posedge clk_sys) wire_feedback_monitor_pin <= 1'b0;
        mode <= 2'h2;
        beams_clear <= 24'h00_0000;
        tick(30);
        @(posedge clk_sys) beams_clear <= 24'hFF_FFFF;
        tick(6);
        chk({safety_switching_output, disp_kind}, 3'b100);
        conclude;
    end
endmodule // testbench
`default_nettype wire
